/* scmfe_front_end.sv */
// Mode front end for four basebands, with an AHB-Lite register slave.
// Assumes samples synchronous to hclk; one lane per baseband is modelled,
// standing for the 32 parallel lanes of the demultiplexed stream.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`default_nettype none

// How it works
// - Four quadrants, each one dual-polarization baseband for up to 64 antennas.
// - Correlation runs at 125 MHz on 32 demultiplexed lanes.
// - Time-division mode routes the baseband past the filter bank.
// - Time-division mode drops each sample's LSB, leaving 2 bits.
// - Time-division gives one window of 256 over polarization products channels.
// - Frequency-division splits the baseband into 32 sub-bands with mixer.
// - Overlapping sub-bands leave 15/16 of each usable.
// - Joined sub-bands give 15/16 of 8192 over products channels.
// - Sub-band count per window selectable as 32, 16, 8, 4, 2 or 1.
// - Averaging of 2, 4, 8 or 16 channels reduces output rate.
// - Up to four spectral windows per baseband.
// - Window centres tune in 30.5 kHz oscillator steps.
// - In 4x4 mode paired banks give MSB and LSB 2-bit chunks.
// - In 4x4 mode four chunk products are rescaled into 4 bits.
module scmfe_front_end (
	// Clock, reset and freeze
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Samples from the digitizers, one 6-bit lane per baseband
	input wire logic [23:0] sample_in,
	// Conditioned lanes and chunk products toward the correlation array
	output logic [31:0] lane_out,
	output logic [15:0] product_out,
	output logic [3:0] bb_valid
);

	typedef struct packed {
		logic [3:0][12:0] cfg;
		logic [3:0][15:0] tune;
		logic [3:0] bad;
		logic [3:0][15:0] prod;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} scmfe_state_t;

	scmfe_state_t state_reg;
	scmfe_state_t state_next;
	logic [3:0][7:0] lane_w;
	logic [3:0] run;
	logic [3:0] cfg_bad;
	logic addr_phase;

	// ---------------------------------------------------------------
	// Lanes, one per quadrant
	// ---------------------------------------------------------------
	// four quadrant lanes
	genvar q;
	generate
		for (q = 0; q < 4; q++) begin : g_quad
			scmfe_pkg::scmfe_bbcfg_t c;
			logic [3:0] ws;
			logic [16:0] hi;
			assign c = scmfe_pkg::scmfe_bbcfg_t'(state_reg.cfg[q]);
			// joined sub-band span
			// Half span in steps doubles with each subband_sel step up to 3; ws is zero for 4 and 5.
			assign ws = 4'(1) << c.subband_sel;
			assign hi = 17'(state_reg.tune[q]) +
				17'(scmfe_pkg::SUBBAND_STEPS * ws);
			assign cfg_bad[q] = (c.mode == scmfe_pkg::SCMFE_MODE_BAD) ||
				(c.pol == scmfe_pkg::SCMFE_POL_BAD) ||
				(c.subband_sel > 3'h5) ||
				(c.avg_sel > 3'h4) ||
				(c.windows == 3'h0) || (c.windows > 3'h4) ||
				((c.mode == scmfe_pkg::SCMFE_TIME_DIV) &&
					(c.windows != 3'h1)) ||
				((c.mode == scmfe_pkg::SCMFE_FOUR_BY_FOUR) &&
					((c.windows != 3'h1) ||
					(c.pol != scmfe_pkg::SCMFE_POL_DUAL))) ||
				((c.mode != scmfe_pkg::SCMFE_TIME_DIV) &&
					(state_reg.tune[q] < 16'(scmfe_pkg::SUBBAND_STEPS * ws)
					|| hi > 17'(scmfe_pkg::TUNE_MAX)));
			assign run[q] = !state_reg.bad[q];
			scmfe_lane u_lane (
				.hclk(hclk),
				.hresetn(hresetn),
				.clk_en(clk_en),
				.mode(c.mode),
				.phase_step(state_reg.tune[q]),
				.run(run[q]),
				.sample_in(sample_in[q*6 +: 6]),
				.lane_out(lane_w[q])
			);
			assign lane_out[q*8 +: 8] = lane_w[q];
			assign product_out[q*4 +: 4] = state_reg.prod[q][15:12];
			assign bb_valid[q] = run[q];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	assign addr_phase = hsel && hready && htrans[1];

	always_comb begin
		logic signed [3:0] ax;
		logic signed [3:0] ay;
		logic signed [7:0] mm;
		logic signed [7:0] ml;
		logic signed [7:0] lm;
		logic signed [7:0] ll;
		logic signed [9:0] acc;
		ax = '0;
		ay = '0;
		mm = '0;
		ml = '0;
		lm = '0;
		ll = '0;
		acc = '0;
		state_next = state_reg;
		state_next.bad = cfg_bad;
		for (int b = 0; b < 4; b++) begin
			ax = {lane_w[b][7:6], 2'b00};
			ay = {lane_w[b][3:2], 2'b00};
			mm = 8'(ax) * 8'(ay);
			ml = 8'(ax) * 8'($signed({2'b00, lane_w[b][1:0]}));
			lm = 8'(ay) * 8'($signed({2'b00, lane_w[b][5:4]}));
			ll = 8'($signed({2'b00, lane_w[b][5:4]})) *
				8'($signed({2'b00, lane_w[b][1:0]}));
			if (state_reg.cfg[b][12:11] == 2'(scmfe_pkg::SCMFE_FOUR_BY_FOUR)) begin
				acc = 10'(mm) + 10'(ml) + 10'(lm) + 10'(ll >>> 2);
			end else begin
				acc = 10'(mm);
			end
			state_next.prod[b] = {acc[9:6], 12'h000};
		end
		if (addr_phase) begin
			state_next.wr_pend = hwrite;
			state_next.wr_addr = haddr[7:0];
			state_next.rdata = '0;
			if (haddr[7:0] == scmfe_pkg::MODE_OFS) begin
				for (int b = 0; b < 4; b++) begin
					state_next.rdata[b*8 +: 8] = {3'h0, state_reg.cfg[b][12:8]};
				end
			end else if (haddr[7:0] == scmfe_pkg::WINCFG_OFS) begin
				for (int b = 0; b < 4; b++) begin
					state_next.rdata[b*8 +: 8] = {state_reg.cfg[b][7:0]};
				end
			end else if (haddr[7:0] == scmfe_pkg::STATUS_OFS) begin
				state_next.rdata = {28'h0, state_reg.bad};
			end else if (haddr[7:4] == scmfe_pkg::TUNE0_OFS[7:4] &&
				haddr[3:2] != 2'h3) begin
				state_next.rdata = {16'h0, state_reg.tune[haddr[3:2]]};
			end else if (haddr[7:0] == 8'h1c) begin
				state_next.rdata = {16'h0, state_reg.tune[3]};
			end
		end else if (hready) begin
			state_next.wr_pend = 1'b0;
		end
		if (state_reg.wr_pend) begin
			for (int b = 0; b < 4; b++) begin
				if (state_reg.wr_addr == scmfe_pkg::MODE_OFS) begin
					state_next.cfg[b][12:8] = hwdata[b*8 +: 5];
				end
				if (state_reg.wr_addr == scmfe_pkg::WINCFG_OFS) begin
					state_next.cfg[b][7:0] = hwdata[b*8 +: 8];
				end
				if (state_reg.wr_addr == 8'(scmfe_pkg::TUNE0_OFS + 8'(b*4))) begin
					state_next.tune[b] = hwdata[15:0];
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '{bad: scmfe_pkg::BAD_RESET, default: '0};
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign hrdata = state_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

endmodule

`default_nettype wire

/* scmfe_pkg.sv */
// Package for the correlator mode front end: modes, register map, limits.
// Assumes a single 25 MHz bus clock and an AHB-Lite register port.
`default_nettype none

package scmfe_pkg;

	// -----------------------------------------------------------------
	// Sizes and limits
	// -----------------------------------------------------------------
	localparam int unsigned QUADRANTS = 4;
	localparam int unsigned MAX_ANTENNAS = 64;
	localparam int unsigned LANES = 32;
	localparam int unsigned SUB_BANDS = 32;
	localparam int unsigned MAX_WINDOWS = 4;
	localparam int unsigned TDM_CHANNELS = 256;
	localparam int unsigned FINE_DIV_CHANNELS = 8192;
	localparam int unsigned USABLE_NUM = 15;
	localparam int unsigned USABLE_DEN = 16;
	localparam int unsigned SAMPLE_BITS = 3;
	localparam int unsigned TDM_BITS = 2;
	localparam int unsigned PRODUCT_BITS = 4;
	// Tuning word: 2 GHz span in 30.5 kHz steps fits in 16 bits.
	localparam int unsigned TUNE_BITS = 16;
	localparam logic [15:0] TUNE_MAX = 16'hffff;
	// Half window span, in tuning steps, for one sub-band (58.59375 MHz).
	localparam logic [15:0] SUBBAND_STEPS = 16'h0780;

	// -----------------------------------------------------------------
	// Register map (byte offsets)
	// -----------------------------------------------------------------
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] WINCFG_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] TUNE0_OFS = 8'h10;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [31:0] WINCFG_RESET = 32'h0000_0000;
	// Every baseband starts flagged invalid, as its cleared setup is.
	localparam logic [3:0] BAD_RESET = 4'hf;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCMFE_TIME_DIV,
		SCMFE_FREQ_DIV,
		SCMFE_FOUR_BY_FOUR,
		SCMFE_MODE_BAD
	} scmfe_mode_t;

	typedef enum logic [1:0] {
		SCMFE_POL_SINGLE,
		SCMFE_POL_DUAL,
		SCMFE_POL_FULL,
		SCMFE_POL_BAD
	} scmfe_pol_t;

	// Per-baseband configuration as software writes it.
	typedef struct packed {
		scmfe_mode_t mode;
		scmfe_pol_t pol;
		logic [2:0] subband_sel;
		logic [2:0] avg_sel;
		logic [2:0] windows;
	} scmfe_bbcfg_t;

	// One lane of one quadrant: two polarizations of 3-bit samples.
	typedef struct packed {
		logic [SAMPLE_BITS-1:0] pol_x;
		logic [SAMPLE_BITS-1:0] pol_y;
	} scmfe_sample_t;

	// Conditioned lane toward the correlation array.
	typedef struct packed {
		logic [TDM_BITS-1:0] msb_x;
		logic [TDM_BITS-1:0] lsb_x;
		logic [TDM_BITS-1:0] msb_y;
		logic [TDM_BITS-1:0] lsb_y;
	} scmfe_lane_t;

endpackage

`default_nettype wire

/* scmfe_lane.sv */
// One lane of one baseband: truncation, requantizer pair and mixing.
// Assumes samples arrive once per enabled clock, synchronous to hclk.
`default_nettype none

module scmfe_lane (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Configuration
	input wire logic [1:0] mode,
	input wire logic [15:0] phase_step,
	input wire logic run,
	// Data
	input wire logic [5:0] sample_in,
	output logic [7:0] lane_out
);

	typedef struct packed {
		logic [15:0] phase;
		logic [7:0] out;
	} scmfe_lane_state_t;

	scmfe_lane_state_t state_reg;
	scmfe_lane_state_t state_next;
	scmfe_pkg::scmfe_sample_t smp;
	scmfe_pkg::scmfe_lane_t res;
	logic flip;

	always_comb begin
		smp = scmfe_pkg::scmfe_sample_t'(sample_in);
		state_next = state_reg;
		res = '0;
		// The oscillator sign flips the sample in the upper half cycle.
		flip = state_reg.phase[15];
		unique case (scmfe_pkg::scmfe_mode_t'(mode))
			scmfe_pkg::SCMFE_TIME_DIV: begin
				res.msb_x = smp.pol_x[2:1];
				res.msb_y = smp.pol_y[2:1];
			end
			scmfe_pkg::SCMFE_FREQ_DIV: begin
				res.msb_x = flip ? ~smp.pol_x[2:1] : smp.pol_x[2:1];
				res.msb_y = flip ? ~smp.pol_y[2:1] : smp.pol_y[2:1];
			end
			scmfe_pkg::SCMFE_FOUR_BY_FOUR: begin
				res.msb_x = flip ? ~smp.pol_x[2:1] : smp.pol_x[2:1];
				res.lsb_x = {flip ^ smp.pol_x[0], 1'b1};
				res.msb_y = flip ? ~smp.pol_y[2:1] : smp.pol_y[2:1];
				res.lsb_y = {flip ^ smp.pol_y[0], 1'b1};
			end
			default: res = '0;
		endcase
		if (run) begin
			state_next.phase = state_reg.phase + phase_step;
			state_next.out = res;
		end else begin
			state_next.out = '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign lane_out = state_reg.out;

endmodule

`default_nettype wire

/* scmfe_front_end_assertions.sv */
// Checker on the ports of the mode front end.
// Assumes one clock domain and hready tied back to hreadyout.
`default_nettype none

module scmfe_fe_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Data
	input wire logic [31:0] lane_out,
	input wire logic [15:0] product_out,
	input wire logic [3:0] bb_valid
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic acc;
	logic [2:0] wr_age_reg;
	assign acc = hsel && hready && htrans[1] && clk_en;

	// Cycles since the last accepted write, saturating.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_age_reg <= 3'h7;
		end else if (acc && hwrite) begin
			wr_age_reg <= 3'h0;
		end else if (wr_age_reg != 3'h7) begin
			wr_age_reg <= wr_age_reg + 3'h1;
		end
	end

	sequence s_rd(logic [7:0] a);
		acc && !hwrite && haddr == {24'h0, a};
	endsequence
	sequence s_rd_hole;
		acc && !hwrite && haddr[31:8] == 24'h0 &&
			(haddr[7:0] == 8'h0c || haddr[7:0] >= 8'h20);
	endsequence

	a_ready_high: assert property (hreadyout == 1'b1)
		else $error("ready dropped");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
	a_idle_zero: assert property ((bb_valid == 4'h0) [*3]
		|-> $past(lane_out) == 32'h0 && product_out == 16'h0)
		else $error("idle lanes not zero");
	a_rdata_hold: assert property (!$past(acc) |-> $stable(hrdata))
		else $error("read data moved");
	a_hole_zero: assert property (s_rd_hole |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_status_flags: assert property (s_rd(scmfe_pkg::STATUS_OFS)
		|=> hrdata[3:0] == ~$past(bb_valid))
		else $error("status disagrees with valid");
	a_valid_cause: assert property ($changed(bb_valid)
		|-> wr_age_reg < 3'h6)
		else $error("valid moved without a write");
	a_freeze_hold: assert property (!clk_en |=> $stable(lane_out) &&
		$stable(product_out) && $stable(bb_valid) && $stable(hrdata))
		else $error("state moved while frozen");
endmodule

`default_nettype wire

/* scmfe_digitizer.sv */
// Digitizer model: four basebands of dual-polarization 3-bit samples.
// Assumes the bench clock; lanes 0 to 2 change on every cycle, lane 3 on every fourth.
`default_nettype none

module scmfe_digitizer (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Samples
	output logic [23:0] sample_in
);
	logic [7:0] step_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_reg <= 8'h00;
			sample_in <= 24'h0;
		end else begin
			step_reg <= step_reg + 8'h01;
			sample_in <= {step_reg, step_reg + 8'h35, step_reg ^ 8'ha6};
		end
	end
endmodule

`default_nettype wire

/* scmfe_front_end_test.sv */
// Bench for the mode front end: bus tasks, lane and validity tests.
// Assumes the digitizer model drives the samples.
`default_nettype none

module scmfe_front_end_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] lane_out;
	logic hreadyout;
	logic hresp;
	logic [15:0] product_out;
	logic [3:0] bb_valid;
	logic [23:0] sample_in;
	logic [23:0] seen;
	logic [31:0] rd;
	int bad_count = 0;
	int tests_run = 0;
	// Entries are tuning word, mode byte and window byte of baseband 0.
	localparam logic [31:0] CFG [12] = '{
		32'h0000_1801, 32'h0000_0002, 32'h0000_0a04,
		32'h8000_0a04, 32'h8000_0a05, 32'h8000_0b81,
		32'h8000_0a21, 32'h8000_0a29, 32'h8000_1001,
		32'h8000_1201, 32'h8000_1202, 32'h0000_0001};
	localparam logic [11:0] OK_MASK = 12'ha48;

	always #20 hclk = ~hclk;

	scmfe_front_end dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sample_in(sample_in), .lane_out(lane_out),
		.product_out(product_out), .bb_valid(bb_valid));
	scmfe_digitizer adc (.hclk(hclk), .hresetn(hresetn),
		.sample_in(sample_in));

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		wrap_up();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk("mode", scmfe_pkg::MODE_OFS, scmfe_pkg::MODE_RESET);
		rdchk("win", scmfe_pkg::WINCFG_OFS, scmfe_pkg::WINCFG_RESET);
		rdchk("status", scmfe_pkg::STATUS_OFS, 32'hf);
		bus(1'b1, 8'h40, 32'hffff_ffff);
		rdchk("unmapped", 8'h40, 32'h0);
		rdchk("hole", 8'h0c, 32'h0);
		$display("test reset done");
		bus(1'b1, scmfe_pkg::WINCFG_OFS, 32'h0101_0101);
		rdchk("win", scmfe_pkg::WINCFG_OFS, 32'h0101_0101);
		repeat (3) @(posedge hclk);
		check("valid", 32'hf, {28'h0, bb_valid});
		repeat (8) begin
			@(negedge hclk);
			seen = sample_in;
			@(negedge hclk);
			for (int b = 0; b < 4; b++) begin
				check("trunc", {28'h0, seen[6*b+4 +: 2], seen[6*b+1 +: 2]},
					{28'h0, lane_out[8*b+6 +: 2], lane_out[8*b+2 +: 2]});
			end
		end
		@(posedge hclk);
		clk_en <= 1'b0;
		repeat (3) @(posedge hclk);
		clk_en <= 1'b1;
		$display("test time division done");
		for (int i = 0; i < 12; i++) begin
			bus(1'b1, scmfe_pkg::TUNE0_OFS, {16'h0, CFG[i][31:16]});
			bus(1'b1, scmfe_pkg::MODE_OFS, {24'h0, CFG[i][15:8]});
			bus(1'b1, scmfe_pkg::WINCFG_OFS, {24'h010101, CFG[i][7:0]});
			repeat (4) @(posedge hclk);
			check("valid0", {31'h0, OK_MASK[i]}, {31'h0, bb_valid[0]});
			rdchk("status", scmfe_pkg::STATUS_OFS, {31'h0, !OK_MASK[i]});
		end
		$display("test config table done");
		wrap_up();
	end
endmodule

bind scmfe_front_end scmfe_fe_checker u_chk (.hclk(hclk),
	.hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .lane_out(lane_out),
	.product_out(product_out), .bb_valid(bb_valid));

`default_nettype wire
